// [sim/spf_host.sv]
// host side model: drives the serial pins and collects the answer
`timescale 1ns/10ps
module spf_host (
    // serial pins
    output logic      cs_b_o,
    output logic      sck_o,
    output logic      si_o,
    input  wire logic so_i
);
    logic [255:0] rx;
    initial begin
        cs_b_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
        rx     = '0;
    end
    // ====
    // one frame: opcode and address msb first, zero dummies
    // whole frames only
    task automatic frame(input logic [31:0] tx, input int nbits);
        int i;
        cs_b_o = 1'b0;
        for (i = 0; i < nbits; i++) begin
            si_o = (i < 32) ? tx[31-i] : 1'b0;
            #24 sck_o = 1'b1;
            // answer taken on the rising edge
            rx = {rx[254:0], so_i};
            #24 sck_o = 1'b0;
        end
        #24 cs_b_o = 1'b1;
        // no pull on the line, so show the opposite level
        si_o = ~si_o;
        #100;
    endtask : frame
endmodule : spf_host

// [sim/spf_top_checker.sv]
// port assertions of the sleep, reset and parameter block
`timescale 1ns/10ps
module spf_top_checker
    import spf_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // serial pins
    input wire logic cs_b_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe_b_o,
    // write engine and control
    input wire logic write_busy_i,
    input wire logic suspended_flag_i,
    input wire logic deep_sleep_o,
    input wire logic reset_busy_o,
    input wire logic reset_armed_o,
    input wire logic abort_write_o,
    input wire logic clear_status_o,
    input wire logic data_corrupt_o
);
    // ====
    // length of the reset time in clocks
    logic [8:0] busy_len;
    logic [8:0] next_busy_len;
    always_comb begin
        next_busy_len = reset_busy_o ? busy_len + 9'h001 : 9'h000;
    end
    always_ff @(posedge clock_i) begin
        busy_len <= next_busy_len;
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // ====
    // assertions
    a_abort_one_cycle: assert property (
        abort_write_o |=> !abort_write_o) else $error("abort too long");
    a_clear_with_abort: assert property (
        abort_write_o |-> clear_status_o) else $error("no status clear");
    a_corrupt_cause: assert property (
        abort_write_o |-> data_corrupt_o == (write_busy_i | suspended_flag_i))
        else $error("corrupt flag wrong");
    a_corrupt_only_abort: assert property (
        data_corrupt_o |-> abort_write_o) else $error("stray corrupt");
    a_busy_follows: assert property (
        abort_write_o |-> ##[0:2] reset_busy_o) else $error("no reset time");
    a_reset_length: assert property (
        $fell(reset_busy_o) |-> busy_len == 9'(RST_CYCLES))
        else $error("reset time length wrong");
    a_exec_deselected: assert property (
        abort_write_o |-> cs_b_i) else $error("reset while selected");
    a_sleep_entry: assert property (
        $rose(deep_sleep_o) |-> cs_b_i && !write_busy_i)
        else $error("bad sleep entry");
    a_wake_deselected: assert property (
        $fell(deep_sleep_o) |-> cs_b_i) else $error("wake while selected");
    a_released_idle: assert property (
        cs_b_i [*6] |-> so_oe_b_o && !so_o) else $error("output not released");
    a_disarm_deselected: assert property (
        $fell(reset_armed_o) |-> cs_b_i) else $error("disarm while selected");

    c_reset: cover property (abort_write_o);
    c_sleep: cover property ($rose(deep_sleep_o));
    c_drive: cover property ($fell(so_oe_b_o));
endmodule : spf_top_checker

bind spf_top spf_top_checker spf_top_checker_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
    .sck_i(sck_i), .si_i(si_i), .so_o(so_o), .so_oe_b_o(so_oe_b_o),
    .write_busy_i(write_busy_i), .suspended_flag_i(suspended_flag_i),
    .deep_sleep_o(deep_sleep_o), .reset_busy_o(reset_busy_o),
    .reset_armed_o(reset_armed_o), .abort_write_o(abort_write_o),
    .clear_status_o(clear_status_o), .data_corrupt_o(data_corrupt_o));

// [sim/spf_top_tb.sv]
// self-checking bench of the sleep, reset and parameter block
`timescale 1ns/10ps
module spf_top_tb;
    import spf_pkg::*;
    // ====
    // id values, arbitrary
    localparam logic [7:0] DEV_ID = 8'h4d;
    localparam logic [7:0] VEN_ID = 8'h2e;
    localparam logic [7:0] HDR [0:23] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h05, 8'h01, 8'h02, 8'hff,
        8'h00, 8'h00, 8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'hff,
        VEN_ID, 8'h00, 8'h01, 8'h04, 8'hc0, 8'h00, 8'h00, 8'hff};
    logic        clock_i, rst_b_i, cs_b, sck, si, so, so_oe_b;
    logic        wbusy, susp, sleep, rbusy, armed, abort, clr, corrupt;
    logic        saw_abort, saw_bad;
    logic [31:0] r;
    int          failures = 0, check_count = 0, seed = 60;
    int          m_sleep, m_armed, i;

    spf_top #(.DEVICE_ID(DEV_ID), .VENDOR_ID(VEN_ID)) spf_top_inst (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b),
        .sck_i(sck), .si_i(si), .so_o(so), .so_oe_b_o(so_oe_b),
        .write_busy_i(wbusy), .suspended_flag_i(susp),
        .deep_sleep_o(sleep), .reset_busy_o(rbusy),
        .reset_armed_o(armed), .abort_write_o(abort),
        .clear_status_o(clr), .data_corrupt_o(corrupt));
    // released output floats: the host sees the opposite level
    spf_host spf_host_inst (.cs_b_o(cs_b), .sck_o(sck), .si_o(si),
        .so_i(so_oe_b ? ~so : so));

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // one-cycle pulses are latched here for later checks
    always @(posedge clock_i) begin
        if (abort && clr) saw_abort <= 1'b1;
        if (corrupt) saw_bad <= 1'b1;
    end

    // ====
    // comparison and closing report
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    // ====
    // one frame, then the reference model and the flag checks
    task automatic op(input logic [31:0] tx, input int nbits);
        logic [7:0] opc;
        logic       fire;
        opc  = tx[31:24];
        fire = !m_sleep && nbits == 8 && opc == OP_RESET && m_armed;
        spf_host_inst.frame(tx, nbits);
        if (m_sleep) begin
            if (opc == OP_WAKE_ID) m_sleep = 0;
        end else begin
            if (opc == OP_DEEP_SLEEP && nbits == 8 && !wbusy) m_sleep = 1;
            // any other frame drops the arm
            m_armed = opc == OP_RESET_ARM && nbits == 8;
        end
        check("deep_sleep", {7'h0, sleep}, 8'(m_sleep));
        check("reset_armed", {7'h0, armed}, 8'(m_armed));
        check("reset_busy", {7'h0, rbusy}, {7'h0, fire});
    endtask : op

    task automatic pread(input logic [23:0] a, input int n);
        int         k;
        int         ad;
        logic [7:0] e;
        op({OP_PARAM_READ, a}, 40 + 8 * n);
        for (k = 0; k < n; k++) begin
            ad = (int'(a[10:0]) + k) % 2048;
            e  = m_sleep ? 8'hff : (ad < 24 ? HDR[ad] : 8'hff);
            check("param_byte", spf_host_inst.rx[8*(n-1-k) +: 8], e);
        end
    endtask : pread

    task automatic soft_reset(input logic wb, input logic sp);
        int k;
        @(negedge clock_i);
        wbusy     = wb;
        susp      = sp;
        saw_abort = 1'b0;
        saw_bad   = 1'b0;
        op({OP_RESET_ARM, 24'h0}, 8);
        op({OP_RESET, 24'h0}, 8);
        // host waits out the reset time
        for (k = 0; k < 400 && rbusy; k++) @(negedge clock_i);
        check("reset_busy_end", {7'h0, rbusy}, 8'h00);
        if (rbusy) stop_test();
        check("abort", {7'h0, saw_abort}, 8'h01);
        check("corrupt", {7'h0, saw_bad}, {7'h0, wb | sp});
        wbusy = 1'b0;
        susp  = 1'b0;
    endtask : soft_reset

    // ====
    // main sequence
    initial begin
        rst_b_i   = 1'b0;
        wbusy     = 1'b0;
        susp      = 1'b0;
        saw_abort = 1'b0;
        saw_bad   = 1'b0;
        m_sleep   = 0;
        m_armed   = 0;
        repeat (4) @(negedge clock_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clock_i);
        check("so_enable_b", {7'h0, so_oe_b}, 8'h01);
        pread(24'h000000, 26);
        pread(24'h0007ff, 2);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            pread({r[23:11], 6'h00, r[4:0]}, 3);
        end
        op({OP_WAKE_ID, 24'h0}, 64);
        for (i = 0; i < 4; i++)
            check("id_byte", spf_host_inst.rx[8*i +: 8], DEV_ID);
        op({OP_DEEP_SLEEP, 24'h0}, 8);
        pread(24'h000004, 2);
        op({OP_RESET_ARM, 24'h0}, 8);
        op({OP_WAKE_ID, 24'h0}, 48);
        check("id_byte", spf_host_inst.rx[7:0], DEV_ID);
        op({OP_DEEP_SLEEP, 24'h0}, 8);
        op({OP_WAKE_ID, 24'h0}, 8);
        op({OP_DEEP_SLEEP, 24'h0}, 9);
        @(negedge clock_i);
        wbusy = 1'b1;
        op({OP_DEEP_SLEEP, 24'h0}, 8);
        @(negedge clock_i);
        wbusy = 1'b0;
        soft_reset(1'b1, 1'b0);
        soft_reset(1'b0, 1'b1);
        soft_reset(1'b0, 1'b0);
        // another frame between arm and reset
        op({OP_RESET_ARM, 24'h0}, 8);
        op({OP_WAKE_ID, 24'h0}, 8);
        op({OP_RESET, 24'h0}, 8);
        stop_test();
    end
endmodule : spf_top_tb

// [verilog/spf_fifo.sv]
// byte buffer between the parameter fetch and the serial shifter
`timescale 1ns/10ps
module spf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic             flush_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0]    wp;
    logic [PW-1:0]    rp;
    logic [CW-1:0]    cnt;
    logic [PW-1:0]    next_wp;
    logic [PW-1:0]    next_rp;
    logic [CW-1:0]    next_cnt;
    logic             next_out_valid;
    logic             push;
    logic             load;

    // ========================================================
    // pointer logic
    always_comb begin
        push           = in_valid_i && (cnt != FULL);
        load           = (!out_valid_o || out_ready_i) && (cnt != '0);
        next_wp        = push ? PW'(wp + 1'b1) : wp;
        next_rp        = load ? PW'(rp + 1'b1) : rp;
        next_cnt       = CW'(cnt + CW'(push) - CW'(load));
        next_out_valid = load ? 1'b1 : (out_ready_i ? 1'b0 : out_valid_o);
        if (flush_i) begin
            next_wp        = '0;
            next_rp        = '0;
            next_cnt       = '0;
            next_out_valid = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            wp          <= '0;
            rp          <= '0;
            cnt         <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else begin
            wp          <= next_wp;
            rp          <= next_rp;
            cnt         <= next_cnt;
            out_valid_o <= next_out_valid;
            if (load) begin
                out_data_o <= mem[rp];
            end
        end
    end

    // storage has no reset; cnt guards every read
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end

    assign in_ready_o = (cnt != FULL);

endmodule : spf_fifo

// [verilog/spf_pkg.sv]
// shared constants and types of the serial flash sleep, reset and parameter block
package spf_pkg;

    // ========================================================
    // opcodes
    localparam logic [7:0] OP_DEEP_SLEEP  = 8'hb9;
    localparam logic [7:0] OP_WAKE_ID     = 8'hab;
    localparam logic [7:0] OP_RESET_ARM   = 8'h66;
    localparam logic [7:0] OP_RESET       = 8'h99;
    localparam logic [7:0] OP_PARAM_READ  = 8'h5a;

    // ========================================================
    // serial clock counts within one frame
    localparam logic [5:0] BITS_OPCODE    = 6'h08;
    localparam logic [5:0] BITS_ADDR_DONE = 6'h20;
    localparam logic [5:0] BITS_ID_OUT    = 6'h20;
    localparam logic [5:0] BITS_PARAM_OUT = 6'h28;
    localparam logic [5:0] BIT_CNT_MAX    = 6'h3f;
    localparam logic [2:0] BIT_IN_BYTE_LAST = 3'h7;

    // ========================================================
    // internal reset time
    localparam int         CLK_PERIOD_NS  = 5;
    localparam int         RST_TIME_NS    = 1000;
    localparam int         RST_CYCLES     =
        (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RST_CNT_LOAD   = 8'(RST_CYCLES - 1);

    // ========================================================
    // parameter space
    localparam int         PARAM_ADDR_W   = 11;
    localparam int         FIFO_DEPTH     = 16;
    localparam int         FIFO_WIDTH     = 8;
    localparam logic [7:0] PARAM_FILL     = 8'hff;
    localparam logic [10:0] PARAM_HDR_LEN = 11'h018;
    localparam logic [10:0] PARAM_VID_AT  = 11'h010;
    localparam logic [7:0] PARAM_HDR [0:23] = '{
        8'h53, 8'h46, 8'h44, 8'h50,
        8'h05, 8'h01, 8'h02, 8'hff,
        8'h00, 8'h00, 8'h01, 8'h10,
        8'h40, 8'h00, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h01, 8'h04,
        8'hc0, 8'h00, 8'h00, 8'hff
    };

    // ========================================================
    // device mode
    typedef enum logic [2:0] {
        MODE_STANDBY = 3'b001,
        MODE_SLEEP   = 3'b010,
        MODE_RESET   = 3'b100
    } spf_mode_e;

endpackage : spf_pkg

// [verilog/spf_top.sv]
// command handling for deep sleep, wake with id, soft reset, parameter read
`timescale 1ns/10ps
module spf_top
    import spf_pkg::*;
#(
    // arbitrary value, stands in for the real id codes
    parameter logic [7:0] DEVICE_ID = 8'h5c,
    parameter logic [7:0] VENDOR_ID = 8'h3a
) (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    // serial pins
    input  wire logic cs_b_i,
    input  wire logic sck_i,
    input  wire logic si_i,
    output logic      so_o,
    output logic      so_oe_b_o,
    // write engine status
    input  wire logic write_busy_i,
    input  wire logic suspended_flag_i,
    // control outputs
    output logic      deep_sleep_o,
    output logic      reset_busy_o,
    output logic      reset_armed_o,
    output logic      abort_write_o,
    output logic      clear_status_o,
    output logic      data_corrupt_o
);

    // ========================================================
    // parameter space lookup
    function automatic logic [7:0] param_byte(input logic [10:0] a);
        logic [7:0] b;
        // header bytes, vendor id in the second header
        b = (a < PARAM_HDR_LEN) ? PARAM_HDR[a[4:0]] : PARAM_FILL;
        if (a == PARAM_VID_AT) begin
            b = VENDOR_ID;
        end
        return b;
    endfunction : param_byte

    // ========================================================
    // pin synchronisers: bit 1 is the first one logic may read
    logic [2:0] cs_q;
    logic [2:0] sck_q;
    logic [1:0] si_q;
    logic       cs_low, cs_rise, sck_rise, sck_fall;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            cs_q  <= 3'h7;
            sck_q <= 3'h0;
            si_q  <= 2'h0;
        end else begin
            cs_q  <= {cs_q[1:0], cs_b_i};
            sck_q <= {sck_q[1:0], sck_i};
            si_q  <= {si_q[0], si_i};
        end
    end

    assign cs_low   = !cs_q[1];
    assign cs_rise  = cs_q[1] && !cs_q[2];
    assign sck_rise = cs_low && sck_q[1] && !sck_q[2];
    assign sck_fall = cs_low && !sck_q[1] && sck_q[2];

    // ========================================================
    // frame receiver
    logic [5:0]  bit_cnt, next_bit_cnt;
    logic [7:0]  rx_shift, next_rx_shift;
    logic [7:0]  opcode, next_opcode;
    logic [10:0] addr, next_addr;

    always_comb begin
        next_bit_cnt  = bit_cnt;
        next_rx_shift = rx_shift;
        next_opcode   = opcode;
        next_addr     = addr;
        if (!cs_low) begin
            next_bit_cnt = '0;
        end else if (sck_rise) begin
            next_rx_shift = {rx_shift[6:0], si_q[1]};
            next_bit_cnt  = (bit_cnt == BIT_CNT_MAX) ? bit_cnt :
                            6'(bit_cnt + 1'b1);
            if (bit_cnt == BITS_OPCODE - 1'b1) begin
                next_opcode = {rx_shift[6:0], si_q[1]};
            end
            if (bit_cnt >= BITS_OPCODE && bit_cnt < BITS_ADDR_DONE) begin
                next_addr = {addr[9:0], si_q[1]};
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            bit_cnt  <= '0;
            rx_shift <= '0;
            opcode   <= '0;
            addr     <= '0;
        end else begin
            bit_cnt  <= next_bit_cnt;
            rx_shift <= next_rx_shift;
            opcode   <= next_opcode;
            addr     <= next_addr;
        end
    end

    // ========================================================
    // mode control
    spf_mode_e  mode, next_mode;
    logic       armed, next_armed;
    logic [7:0] rst_cnt, next_rst_cnt;
    logic       next_abort, next_clear, next_corrupt;
    logic       lone_op, got_op;
    assign lone_op = (bit_cnt == BITS_OPCODE);
    assign got_op  = (bit_cnt >= BITS_OPCODE);

    always_comb begin
        next_mode    = mode;
        next_armed   = armed;
        next_rst_cnt = rst_cnt;
        next_abort   = 1'b0;
        next_clear   = 1'b0;
        next_corrupt = 1'b0;
        case (mode)
            MODE_STANDBY: begin
                if (cs_rise && got_op) begin
                    // only a lone arm opcode sets the arm; the next frame with an opcode drops it
                    next_armed = lone_op && (opcode == OP_RESET_ARM);
                    // lone opcode, acted on at rise
                    if (lone_op && opcode == OP_DEEP_SLEEP &&
                        !write_busy_i) begin
                        next_mode = MODE_SLEEP;
                    end
                    if (lone_op && opcode == OP_RESET && armed) begin
                        next_mode    = MODE_RESET;
                        next_rst_cnt = RST_CNT_LOAD;
                        next_abort   = 1'b1;
                        next_clear   = 1'b1;
                        next_corrupt = write_busy_i || suspended_flag_i;
                    end
                end
            end
            MODE_SLEEP: begin
                // id read of any length also wakes
                if (cs_rise && got_op && opcode == OP_WAKE_ID) begin
                    next_mode = MODE_STANDBY;
                end
            end
            MODE_RESET: begin
                // standby after the reset time
                // frames here are ignored, host must wait
                next_armed = 1'b0;
                if (rst_cnt == '0) begin
                    next_mode = MODE_STANDBY;
                end else begin
                    next_rst_cnt = 8'(rst_cnt - 1'b1);
                end
            end
            default: begin
                next_mode  = MODE_STANDBY;
                next_armed = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            mode           <= MODE_STANDBY;
            armed          <= 1'b0;
            rst_cnt        <= '0;
            abort_write_o  <= 1'b0;
            clear_status_o <= 1'b0;
            data_corrupt_o <= 1'b0;
            deep_sleep_o   <= 1'b0;
            reset_busy_o   <= 1'b0;
            reset_armed_o  <= 1'b0;
        end else begin
            mode           <= next_mode;
            armed          <= next_armed;
            rst_cnt        <= next_rst_cnt;
            abort_write_o  <= next_abort;
            clear_status_o <= next_clear;
            data_corrupt_o <= next_corrupt;
            deep_sleep_o   <= (next_mode == MODE_SLEEP);
            reset_busy_o   <= (next_mode == MODE_RESET);
            reset_armed_o  <= next_armed;
        end
    end

    // ========================================================
    // byte fetch into the buffer
    logic        prod_on, next_prod_on;
    logic        prod_id, next_prod_id;
    logic [10:0] prod_addr, next_prod_addr;
    logic        fifo_in_ready, fifo_out_valid, pop;
    logic [7:0]  fifo_out_data, fifo_in_data;
    logic        id_req, param_req;
    // wake-with-id also runs from deep sleep
    assign id_req    = (opcode == OP_WAKE_ID) && got_op &&
                       (mode != MODE_RESET);
    assign param_req = (opcode == OP_PARAM_READ) &&
                       (bit_cnt >= BITS_ADDR_DONE) && (mode == MODE_STANDBY);

    always_comb begin
        next_prod_on   = prod_on;
        next_prod_id   = prod_id;
        next_prod_addr = prod_addr;
        if (!cs_low) begin
            next_prod_on = 1'b0;
        end else if (!prod_on) begin
            if (id_req || param_req) begin
                next_prod_on   = 1'b1;
                next_prod_id   = id_req;
                next_prod_addr = addr;
            end
        end else if (fifo_in_ready) begin
            // next address once a byte is queued
            next_prod_addr = 11'(prod_addr + 1'b1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            prod_on   <= 1'b0;
            prod_id   <= 1'b0;
            prod_addr <= '0;
        end else begin
            prod_on   <= next_prod_on;
            prod_id   <= next_prod_id;
            prod_addr <= next_prod_addr;
        end
    end

    // id byte repeats as long as clocks come
    assign fifo_in_data = prod_id ? DEVICE_ID : param_byte(prod_addr);

    // a full buffer holds the fetch; a stalled shifter fills it
    spf_fifo #(.WIDTH (FIFO_WIDTH), .DEPTH (FIFO_DEPTH)) u_fifo (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .flush_i     (!cs_low),
        .in_valid_i  (prod_on),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out_data)
    );

    // ========================================================
    // serial shifter
    logic       tx_on, next_tx_on;
    logic [2:0] tx_cnt, next_tx_cnt;
    logic [7:0] tx_shift, next_tx_shift;
    logic       next_so, next_so_oe_b;
    logic       tx_start;
    logic [7:0] tx_byte;
    // id from the fall after clock 32 counted from one
    // parameters from the fall after clock 40
    assign tx_start = (id_req && bit_cnt == BITS_ID_OUT) ||
                      (param_req && bit_cnt == BITS_PARAM_OUT);
    // an empty buffer here would be a fetch far slower than sck
    assign tx_byte  = fifo_out_valid ? fifo_out_data : PARAM_FILL;

    always_comb begin
        next_tx_on    = tx_on;
        next_tx_cnt   = tx_cnt;
        next_tx_shift = tx_shift;
        next_so       = so_o;
        next_so_oe_b  = so_oe_b_o;
        pop           = 1'b0;
        if (!cs_low) begin
            next_tx_on   = 1'b0;
            next_tx_cnt  = '0;
            next_so      = 1'b0;
            next_so_oe_b = 1'b1;
        end else if (sck_fall && (tx_on || tx_start)) begin
            next_tx_on   = 1'b1;
            next_so_oe_b = 1'b0;
            next_tx_cnt  = 3'(tx_cnt + 1'b1);
            if (tx_cnt == '0) begin
                pop           = fifo_out_valid;
                next_so       = tx_byte[7];
                next_tx_shift = {tx_byte[6:0], 1'b0};
            end else begin
                next_so       = tx_shift[7];
                next_tx_shift = {tx_shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            tx_on     <= 1'b0;
            tx_cnt    <= '0;
            tx_shift  <= '0;
            so_o      <= 1'b0;
            so_oe_b_o <= 1'b1;
        end else begin
            tx_on     <= next_tx_on;
            tx_cnt    <= next_tx_cnt;
            tx_shift  <= next_tx_shift;
            so_o      <= next_so;
            so_oe_b_o <= next_so_oe_b;
        end
    end

endmodule : spf_top
